/* rtl/fcm_move_ops.sv */
// move-operation decoder: control register moves, constant load, multiple move
// assumes the main processor presents one command word with a one-cycle strobe,
// performs memory accesses, and consumes the image/address stream one per cycle
`default_nettype none
module fcm_move_ops #(
   parameter int NREG = 8 // floating-point data registers
) (
   input wire logic clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic cmd_valid, // command word strobe, one cycle
   input wire logic [15:0] cmd_word, // command word
   input wire logic [5:0] cmd_ea, // effective address mode and register
   input wire logic [31:0] ext_operand, // external operand for control loads
   input wire logic [31:0] dyn_reg, // main processor data register for dynamic lists
   input wire logic [31:0] base_addr, // effective address or address register value
   input wire logic [79:0] img_in, // incoming image for memory-to-register moves
   input wire logic pending_exc, // an exception is pending from earlier ops
   output logic [31:0] ext_result_q, // control register stored outward
   output logic ext_result_valid_q, // pulse with ext_result_q
   output logic [31:0] arith_control_reg_q, // control register
   output logic [31:0] arith_status_reg_q, // status register
   output logic [31:0] instr_address_reg_q, // instruction address register
   output logic xfer_valid_q, // one image transferred this cycle
   output logic xfer_store_q, // 1 image goes to memory, 0 from memory
   output logic [2:0] xfer_reg_q, // register being transferred
   output logic [31:0] xfer_addr_q, // memory address of the image
   output logic [95:0] xfer_img_q, // image, most significant byte at lowest address
   output logic [31:0] final_addr_q, // address register value after the move
   output logic done_q, // pulse when an operation completes
   output logic exc_report_q, // exception reported to main processor
   output logic protocol_err_q, // protocol violation / illegal command
   output logic [79:0] fp_reg_q [NREG] // floating-point data registers
);
   fcm_pkg::fcm_state_t state_q, state_d;
   logic [2:0] dest_q;
   logic [7:0] mask_q;
   logic asc_q, store_q;
   logic [31:0] addr_q;
   logic [79:0] rom_data;

   ////////////////////////////////////////////////////////////////////////////
   // command decode
   wire is_const = cmd_word[15:10] == fcm_pkg::CONST_OPC;
   wire is_ctrl = cmd_word[15:14] == fcm_pkg::CTRL_OPC && cmd_word[9:0] == 10'h000;
   wire is_multi = cmd_word[15:14] == fcm_pkg::MULTI_OPC && cmd_word[10:8] == 3'h0;
   wire dir = cmd_word[13];
   wire [2:0] sel = cmd_word[12:10];
   wire sel_ctrl = sel == fcm_pkg::SEL_CTRL;
   wire sel_stat = sel == fcm_pkg::SEL_STAT;
   wire sel_iaddr = sel == fcm_pkg::SEL_IADDR;
   wire sel_ok = sel_ctrl | sel_stat | sel_iaddr;
   wire [2:0] ea_mode = cmd_ea[5:3];
   wire areg_bad = ea_mode == fcm_pkg::EA_AREG && !sel_iaddr;
   wire ctrl_ok = cmd_valid && is_ctrl && sel_ok && !areg_bad;
   wire ctrl_load = ctrl_ok && !dir;
   wire ctrl_store = ctrl_ok && dir;
   wire [1:0] mm_mode = cmd_word[12:11];
   wire mm_dyn = mm_mode == fcm_pkg::MM_DYN_PRE || mm_mode == fcm_pkg::MM_DYN_POST;
   wire mm_pre = mm_mode == fcm_pkg::MM_STAT_PRE || mm_mode == fcm_pkg::MM_DYN_PRE;
   wire [7:0] raw_mask = mm_dyn ? dyn_reg[7:0] : cmd_word[7:0];
   // predecrement needs a store with -(An); postincrement needs a load
   wire mm_mode_ok = mm_pre ? (dir && ea_mode == fcm_pkg::EA_PREDEC)
                            : !(dir && ea_mode == fcm_pkg::EA_POSTINC)
                              && ea_mode != fcm_pkg::EA_PREDEC;
   wire multi_ok = cmd_valid && is_multi && mm_mode_ok;
   wire const_ok = cmd_valid && is_const && state_q == fcm_pkg::fcm_idle;
   wire illegal = cmd_valid && state_q == fcm_pkg::fcm_idle && !is_const
                  && !ctrl_ok && !multi_ok;

   // mask bit b names register b for predecrement, register 7-b otherwise
   function automatic logic [7:0] fcm_reverse(input logic [7:0] m);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) r[i] = m[7 - i];
      return r;
   endfunction

   // index of lowest set bit of a register-indexed mask
   function automatic logic [2:0] fcm_lowest(input logic [7:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) if (m[i]) r = 3'(i);
      return r;
   endfunction

   // index of highest set bit
   function automatic logic [2:0] fcm_highest(input logic [7:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 8; i++) if (m[i]) r = 3'(i);
      return r;
   endfunction

   // register-indexed mask: bit n set means fp register n moves
   wire [7:0] reg_mask = mm_pre ? raw_mask : fcm_reverse(raw_mask);

   ////////////////////////////////////////////////////////////////////////////
   // constant rom and rounding
   fcm_const_rom u_rom (
      .clk(clk),
      .rst(rst),
      .addr(cmd_word[6:0]),
      .data_q(rom_data)
   );

   wire [1:0] prec = arith_control_reg_q[fcm_pkg::PREC_LSB +: 2];
   wire [79:0] sgl_mask = ~80'h0 << fcm_pkg::SGL_DROP;
   wire [79:0] dbl_mask = ~80'h0 << fcm_pkg::DBL_DROP;
   // rounding by truncation toward zero of the dropped mantissa bits
   wire [79:0] rounded = prec == fcm_pkg::PREC_SGL ? (rom_data & sgl_mask)
                       : prec == fcm_pkg::PREC_DBL ? (rom_data & dbl_mask) : rom_data;
   wire inexact = rounded != rom_data;
   wire res_zero = rounded[62:0] == 63'h0 && rounded[78:64] == 15'h0;
   wire res_inf = rounded[78:64] == 15'h7FFF;
   wire [3:0] cc_new = {rounded[79], res_zero, res_inf, 1'b0};
   // exception byte: only the second inexact flag may be set
   wire [7:0] exc_new = {6'h00, inexact, 1'b0};
   wire [7:0] acc_old = {arith_status_reg_q[7:3], 3'h0};
   wire [7:0] acc_new = acc_old | {4'h0, inexact, 3'h0};
   wire [31:0] stat_after_const = {4'h0, cc_new, arith_status_reg_q[23:16],
                                   exc_new, acc_new};

   ////////////////////////////////////////////////////////////////////////////
   // multiple-move stepping
   wire [2:0] next_reg = asc_q ? fcm_lowest(mask_q) : fcm_highest(mask_q);
   wire [7:0] mask_after = mask_q & ~(8'h01 << next_reg);
   wire [31:0] addr_pre = addr_q - fcm_pkg::IMG_BYTES;
   wire [31:0] addr_post = addr_q + fcm_pkg::IMG_BYTES;
   wire [31:0] img_addr = asc_q ? addr_q : addr_pre;
   wire [31:0] addr_next = asc_q ? addr_post : addr_pre;
   // image: exponent word, sixteen zero bits, mantissa; msb first
   wire [95:0] img_out = {fp_reg_q[next_reg][79:64], 16'h0000, fp_reg_q[next_reg][63:0]};

   // next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         fcm_pkg::fcm_idle: begin
            if (const_ok) state_d = fcm_pkg::fcm_rom;
            else if (multi_ok && reg_mask != 8'h00) state_d = fcm_pkg::fcm_multi;
         end
         fcm_pkg::fcm_rom: state_d = fcm_pkg::fcm_idle;
         fcm_pkg::fcm_multi: if (mask_after == 8'h00) state_d = fcm_pkg::fcm_idle;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and operation registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= fcm_pkg::fcm_idle;
         dest_q <= 3'h0;
         mask_q <= 8'h00;
         asc_q <= 1'b0;
         store_q <= 1'b0;
         addr_q <= 32'h0;
      end else begin
         state_q <= state_d;
         if (state_q == fcm_pkg::fcm_idle && cmd_valid) begin
            dest_q <= cmd_word[9:7];
            mask_q <= reg_mask;
            asc_q <= !mm_pre;
            store_q <= dir;
            addr_q <= base_addr;
         end else if (state_q == fcm_pkg::fcm_multi) begin
            mask_q <= mask_after;
            addr_q <= addr_next;
         end
      end
   end

   // control registers; status untouched by multiple moves
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arith_control_reg_q <= 32'h0;
         arith_status_reg_q <= 32'h0;
         instr_address_reg_q <= 32'h0;
      end else if (state_q == fcm_pkg::fcm_idle && ctrl_load) begin
         // plain writes, no exception check on enable or status bytes
         if (sel_ctrl) arith_control_reg_q <= ext_operand & fcm_pkg::CTRL_MASK;
         if (sel_stat) arith_status_reg_q <= ext_operand & fcm_pkg::STAT_MASK;
         if (sel_iaddr) instr_address_reg_q <= ext_operand;
      end else if (state_q == fcm_pkg::fcm_rom) begin
         arith_status_reg_q <= stat_after_const;
      end
   end

   // data registers: constant result or raw loaded image
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NREG; i++) fp_reg_q[i] <= 80'h0;
      end else if (state_q == fcm_pkg::fcm_rom) begin
         fp_reg_q[dest_q] <= rounded;
      end else if (state_q == fcm_pkg::fcm_multi && !store_q) begin
         fp_reg_q[next_reg] <= img_in;
      end
   end

   // outward control register value, unimplemented bits zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_result_q <= 32'h0;
         ext_result_valid_q <= 1'b0;
      end else begin
         ext_result_valid_q <= state_q == fcm_pkg::fcm_idle && ctrl_store;
         if (state_q == fcm_pkg::fcm_idle && ctrl_store)
            ext_result_q <= sel_ctrl ? arith_control_reg_q
                          : sel_stat ? arith_status_reg_q : instr_address_reg_q;
      end
   end

   // image transfer stream
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xfer_valid_q <= 1'b0;
         xfer_store_q <= 1'b0;
         xfer_reg_q <= 3'h0;
         xfer_addr_q <= 32'h0;
         xfer_img_q <= 96'h0;
         final_addr_q <= 32'h0;
      end else begin
         xfer_valid_q <= state_q == fcm_pkg::fcm_multi;
         xfer_store_q <= store_q;
         xfer_reg_q <= next_reg;
         xfer_addr_q <= img_addr;
         xfer_img_q <= img_out;
         if (state_q == fcm_pkg::fcm_multi) final_addr_q <= addr_next;
         else if (state_q == fcm_pkg::fcm_idle && multi_ok) final_addr_q <= base_addr;
      end
   end

   // completion and reporting; only constant loads report pending exceptions
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
         exc_report_q <= 1'b0;
         protocol_err_q <= 1'b0;
      end else begin
         done_q <= (state_q == fcm_pkg::fcm_rom)
                   || (state_q == fcm_pkg::fcm_multi && mask_after == 8'h00)
                   || (state_q == fcm_pkg::fcm_idle && (ctrl_ok
                       || (multi_ok && reg_mask == 8'h00)));
         exc_report_q <= state_q == fcm_pkg::fcm_rom && pending_exc;
         protocol_err_q <= illegal || (cmd_valid && state_q != fcm_pkg::fcm_idle);
      end
   end
endmodule
`default_nettype wire

/* common/fcm_pkg.sv */
// package for the coprocessor move-operation decoder
// assumes a single clock domain; shared by the decoder and its constant rom
`default_nettype none
package fcm_pkg;
   // command word fields
   localparam int CMD_W = 16;
   localparam logic [5:0] CONST_OPC = 6'h17; // bits 15..10 = 010111
   localparam logic [1:0] CTRL_OPC = 2'h2; // bits 15..14 = 10, bits 9..0 zero
   localparam logic [1:0] MULTI_OPC = 2'h3; // bits 15..14 = 11
   // control register select codes
   localparam logic [2:0] SEL_CTRL = 3'h4;
   localparam logic [2:0] SEL_STAT = 3'h2;
   localparam logic [2:0] SEL_IADDR = 3'h1;
   // effective address modes
   localparam logic [2:0] EA_AREG = 3'h1;
   localparam logic [2:0] EA_POSTINC = 3'h3;
   localparam logic [2:0] EA_PREDEC = 3'h4;
   // multiple-move mode field
   localparam logic [1:0] MM_STAT_PRE = 2'h0;
   localparam logic [1:0] MM_DYN_PRE = 2'h1;
   localparam logic [1:0] MM_STAT_POST = 2'h2;
   localparam logic [1:0] MM_DYN_POST = 2'h3;
   // sizes
   localparam int EXT_W = 80;
   localparam logic [31:0] IMG_BYTES = 32'h0000000C; // one extended image
   // implemented bit masks of the control registers
   localparam logic [31:0] CTRL_MASK = 32'h0000FFFF;
   localparam logic [31:0] STAT_MASK = 32'h0FFFFFF8;
   // status register field positions
   localparam int CC_LSB = 24;
   localparam int EXC_LSB = 8;
   localparam int ACC_LSB = 3;
   localparam int SECOND_INEXACT_FLAG_BIT = 9;
   localparam int FIRST_INEXACT_FLAG_BIT = 8;
   // rounding precision field in control register bits 7..6
   localparam int PREC_LSB = 6;
   localparam logic [1:0] PREC_EXT = 2'h0;
   localparam logic [1:0] PREC_SGL = 2'h1;
   localparam logic [1:0] PREC_DBL = 2'h2;
   localparam int SGL_DROP = 40; // mantissa bits cleared for single
   localparam int DBL_DROP = 11; // mantissa bits cleared for double
   // constant rom offsets
   localparam logic [6:0] ROM_PI = 7'h00;
   localparam logic [6:0] ROM_LOG10_2 = 7'h0B;
   localparam logic [6:0] ROM_E = 7'h0C;
   localparam logic [6:0] ROM_LOG2_E = 7'h0D;
   localparam logic [6:0] ROM_LOG10_E = 7'h0E;
   localparam logic [6:0] ROM_ZERO = 7'h0F;
   localparam logic [6:0] ROM_LN2 = 7'h30;
   localparam logic [6:0] ROM_LN10 = 7'h31;
   localparam logic [6:0] ROM_POW_FIRST = 7'h32;
   localparam logic [6:0] ROM_POW_LAST = 7'h3F;
   // decoder states
   typedef enum logic [1:0] {fcm_idle, fcm_rom, fcm_multi} fcm_state_t;
endpackage
`default_nettype wire

/* rtl/fcm_const_rom.sv */
// constant rom of extended-precision values, registered read data
// assumes the caller holds the offset for one cycle and takes data the next
`default_nettype none
module fcm_const_rom (
   input wire logic clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [6:0] addr, // rom offset
   output logic [79:0] data_q // constant, one cycle after addr
);
   logic [79:0] data_d;

   // listed constants; all other offsets read as zero
   always_comb begin
      unique case (addr)
         fcm_pkg::ROM_PI: data_d = 80'h4000C90FDAA22168C235;
         fcm_pkg::ROM_LOG10_2: data_d = 80'h3FFD9A209A84FBCFF799;
         fcm_pkg::ROM_E: data_d = 80'h4000ADF85458A2BB4A9B;
         fcm_pkg::ROM_LOG2_E: data_d = 80'h3FFFB8AA3B295C17F0BC;
         fcm_pkg::ROM_LOG10_E: data_d = 80'h3FFDDE5BD8A937287195;
         fcm_pkg::ROM_ZERO: data_d = 80'h00000000000000000000;
         fcm_pkg::ROM_LN2: data_d = 80'h3FFEB17217F7D1CF79AC;
         fcm_pkg::ROM_LN10: data_d = 80'h4000935D8DDDAAA8AC17;
         7'h32: data_d = 80'h3FFF8000000000000000;
         7'h33: data_d = 80'h4002A000000000000000;
         7'h34: data_d = 80'h4005C800000000000000;
         7'h35: data_d = 80'h400C9C40000000000000;
         7'h36: data_d = 80'h4019BEBC200000000000;
         7'h37: data_d = 80'h40348E1BC9BF04000000;
         7'h38: data_d = 80'h40699DC5ADA82B70B59E;
         7'h39: data_d = 80'h40D3C2781F49FFCFA6D5;
         7'h3A: data_d = 80'h41A893BA47C980E98CE0;
         7'h3B: data_d = 80'h4351AA7EEBFB9DF9DE8E;
         7'h3C: data_d = 80'h46A3E319A0AEA60E91C7;
         7'h3D: data_d = 80'h4D48C976758681750C17;
         7'h3E: data_d = 80'h5A929E8B3B5DC53D5DE5;
         7'h3F: data_d = 80'h7525C46052028A20979B;
         default: data_d = 80'h00000000000000000000;
      endcase
   end

   // registered read port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) data_q <= 80'h00000000000000000000;
      else data_q <= data_d;
   end
endmodule
`default_nettype wire

/* sim/fcm_move_ops_properties.sv */
// checker for the move-operation decoder, bound to its top module
// assumes one clock, commands issued only while the decoder is idle
`default_nettype none
module fcm_move_ops_properties (
   input wire logic clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic cmd_valid, // command strobe
   input wire logic [15:0] cmd_word, // command word
   input wire logic [5:0] cmd_ea, // ea mode and register
   input wire logic [31:0] ext_operand, // control load operand
   input wire logic [31:0] ext_result_q, // stored control register
   input wire logic ext_result_valid_q, // store pulse
   input wire logic [31:0] arith_control_reg_q, // control register
   input wire logic [31:0] arith_status_reg_q, // status register
   input wire logic [31:0] instr_address_reg_q, // address register
   input wire logic xfer_valid_q, // image moved
   input wire logic xfer_store_q, // image direction
   input wire logic [2:0] xfer_reg_q, // register moved
   input wire logic [31:0] xfer_addr_q, // image address
   input wire logic [95:0] xfer_img_q, // image
   input wire logic done_q, // completion pulse
   input wire logic exc_report_q, // exception report
   input wire logic protocol_err_q // refusal pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // command classes
   wire logic [2:0] sel = cmd_word[12:10];
   wire logic is_ctrl = cmd_valid && cmd_word[15:14] == fcm_pkg::CTRL_OPC
      && cmd_word[9:0] == 10'h000;
   wire logic sel_ok = sel == fcm_pkg::SEL_CTRL || sel == fcm_pkg::SEL_STAT
      || sel == fcm_pkg::SEL_IADDR;
   sequence ctrl_load_s; is_ctrl && !cmd_word[13] && sel == fcm_pkg::SEL_CTRL; endsequence
   sequence stat_store_s;
      is_ctrl && cmd_word[13] && sel == fcm_pkg::SEL_STAT && cmd_ea[5:3] != fcm_pkg::EA_AREG;
   endsequence
   sequence const_s; cmd_valid && cmd_word[15:10] == fcm_pkg::CONST_OPC; endsequence
   sequence step_s; xfer_valid_q && $past(xfer_valid_q); endsequence
   ////////////////////////////////////////////////////////////////////////////////
   ctrl_load_a: assert property (ctrl_load_s |=> done_q &&
      arith_control_reg_q == ($past(ext_operand) & fcm_pkg::CTRL_MASK))
      else $error("control load wrong");
   status_store_a: assert property (stat_store_s |=> ext_result_valid_q &&
      ext_result_q == $past(arith_status_reg_q)) else $error("status store wrong");
   areg_store_a: assert property (is_ctrl && cmd_word[13] &&
      cmd_ea[5:3] == fcm_pkg::EA_AREG && sel != fcm_pkg::SEL_IADDR
      |=> protocol_err_q && !ext_result_valid_q) else $error("areg store taken");
   bad_select_a: assert property (is_ctrl && !sel_ok |=> protocol_err_q &&
      $stable(arith_control_reg_q) && $stable(arith_status_reg_q) &&
      $stable(instr_address_reg_q))
      else $error("illegal select altered state");
   const_status_a: assert property (const_s |-> ##2 done_q &&
      arith_status_reg_q[15:10] == 6'h00 && !arith_status_reg_q[8] &&
      arith_status_reg_q[23:16] == $past(arith_status_reg_q[23:16], 2))
      else $error("constant status wrong");
   down_step_a: assert property (step_s ##0 xfer_reg_q < $past(xfer_reg_q) |->
      xfer_store_q && xfer_addr_q == $past(xfer_addr_q) - 32'h0000000C)
      else $error("predecrement step wrong");
   up_step_a: assert property (step_s ##0 xfer_reg_q > $past(xfer_reg_q) |->
      xfer_addr_q == $past(xfer_addr_q) + 32'h0000000C) else $error("ascending step wrong");
   multi_quiet_a: assert property (xfer_valid_q |-> !exc_report_q &&
      $stable(arith_status_reg_q)) else $error("multi move touched status");
   img_layout_a: assert property (xfer_valid_q && xfer_store_q |->
      xfer_img_q[79:64] == 16'h0000) else $error("image pad not zero");
   impl_bits_a: assert property ((arith_control_reg_q & ~fcm_pkg::CTRL_MASK) == 32'h0 &&
      (arith_status_reg_q & ~fcm_pkg::STAT_MASK) == 32'h0) else $error("unimplemented bits set");
endmodule
bind fcm_move_ops fcm_move_ops_properties u_props (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
   .cmd_word(cmd_word), .cmd_ea(cmd_ea), .ext_operand(ext_operand), .ext_result_q(ext_result_q),
   .ext_result_valid_q(ext_result_valid_q), .arith_control_reg_q(arith_control_reg_q),
   .arith_status_reg_q(arith_status_reg_q), .instr_address_reg_q(instr_address_reg_q),
   .xfer_valid_q(xfer_valid_q), .xfer_store_q(xfer_store_q), .xfer_reg_q(xfer_reg_q),
   .xfer_addr_q(xfer_addr_q), .xfer_img_q(xfer_img_q), .done_q(done_q),
   .exc_report_q(exc_report_q), .protocol_err_q(protocol_err_q));
`default_nettype wire

/* sim/fcm_host_mem.sv */
// memory side of the main processor: offers load images, logs what was taken
// assumes images are sampled one cycle before the register index shows
`default_nettype none
module fcm_host_mem (
   input wire logic clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic xfer_valid_q, // image moved
   input wire logic xfer_store_q, // image direction
   input wire logic [2:0] xfer_reg_q, // register moved
   output logic [79:0] img_in // image offered for loads
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [63:0] lfsr_q;
   logic [79:0] prev_q;
   logic [79:0] ld [8];
   // a new pattern every cycle, so a sample taken a cycle off never matches
   assign img_in = {lfsr_q[47:32], lfsr_q};
   // log the image sampled the cycle before each load transfer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lfsr_q <= 64'hACE1_0F0F_5A5A_3C3C;
         prev_q <= '0;
      end else begin
         lfsr_q <= {lfsr_q[62:0], lfsr_q[63] ^ lfsr_q[62] ^ lfsr_q[60] ^ lfsr_q[59]};
         prev_q <= img_in;
         if (xfer_valid_q && !xfer_store_q) ld[xfer_reg_q] <= prev_q;
      end
   end
endmodule
`default_nettype wire

/* sim/fcm_move_ops_tb.sv */
// self-checking bench for the move-operation decoder
// assumes fcm_pkg compiled first; host memory model supplies load images
`default_nettype none
module fcm_move_ops_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, cmd_valid, pending_exc, err, rep, ext_result_valid_q, xfer_valid_q;
   logic xfer_store_q, done_q, exc_report_q, protocol_err_q, pre, dir;
   logic [15:0] cmd_word;
   logic [5:0] cmd_ea, cf [5];
   logic [31:0] ext_operand, dyn_reg, base_addr, ext_result_q, arith_control_reg_q, v;
   logic [31:0] arith_status_reg_q, instr_address_reg_q, xfer_addr_q, final_addr_q, seed;
   logic [31:0] cv [3];
   logic [2:0] xfer_reg_q, r, xr [16];
   logic [95:0] xfer_img_q, xi [16];
   logic [79:0] img_in, ex, fpm [8];
   logic [79:0] fp_reg_q [8];
   logic [31:0] xa [16];
   logic [7:0] m;
   logic xs [16];
   int n_mismatch, num_checks, nx, k;
   fcm_move_ops uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .cmd_ea(cmd_ea), .ext_operand(ext_operand), .dyn_reg(dyn_reg), .base_addr(base_addr),
      .img_in(img_in), .pending_exc(pending_exc), .ext_result_q(ext_result_q),
      .ext_result_valid_q(ext_result_valid_q), .arith_control_reg_q(arith_control_reg_q),
      .arith_status_reg_q(arith_status_reg_q), .instr_address_reg_q(instr_address_reg_q),
      .xfer_valid_q(xfer_valid_q), .xfer_store_q(xfer_store_q), .xfer_reg_q(xfer_reg_q),
      .xfer_addr_q(xfer_addr_q), .xfer_img_q(xfer_img_q), .final_addr_q(final_addr_q),
      .done_q(done_q), .exc_report_q(exc_report_q), .protocol_err_q(protocol_err_q),
      .fp_reg_q(fp_reg_q));
   fcm_host_mem mem (.clk(clk), .rst(rst), .xfer_valid_q(xfer_valid_q),
      .xfer_store_q(xfer_store_q), .xfer_reg_q(xfer_reg_q), .img_in(img_in));
   ////////////////////////////////////////////////////////////////////////////////
   // xorshift source, compare, verdict
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // list bit of a register: postincrement and control lists run the other way round
   function automatic logic listed(logic p, logic [7:0] mk, logic [2:0] rg);
      return p ? mk[rg] : mk[3'h7 - rg];
   endfunction
   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one command, then gather transfers until completion or refusal
   task automatic run(input logic [15:0] w, input logic [5:0] ea);
      @(negedge clk) cmd_valid = 1'b1;
      cmd_word = w;
      cmd_ea = ea;
      @(negedge clk) cmd_valid = 1'b0;
      {nx, err, rep} = '0;
      for (int i = 0; i < 40; i++) begin
         if (xfer_valid_q === 1'b1) begin
            {xr[nx], xa[nx], xs[nx], xi[nx]} = {xfer_reg_q, xfer_addr_q, xfer_store_q, xfer_img_q};
            nx++;
         end
         if (exc_report_q === 1'b1) rep = 1'b1;
         if (protocol_err_q === 1'b1) err = 1'b1;
         if (done_q === 1'b1 || err) break;
         @(negedge clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000 n_mismatch++;
      tally_and_finish();
   end
   initial begin
      {rst, cmd_valid, pending_exc, cmd_word, cmd_ea, ext_operand, dyn_reg, base_addr} = '0;
      rst = 1'b1;
      seed = 32'h0001_0045;
      cf = '{{1'b0, 2'h2, 3'h3}, {1'b1, 2'h0, 3'h4}, {1'b1, 2'h1, 3'h4}, {1'b0, 2'h3, 3'h2},
         {1'b1, 2'h2, 3'h5}};
      for (int i = 0; i < 8; i++) fpm[i] = '0;
      repeat (4) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      chk({arith_control_reg_q, arith_status_reg_q, done_q, xfer_valid_q}, '0);
      // control register loads and stores, each select code
      for (int i = 0; i < 3; i++) begin
         v = rnd();
         ext_operand = v;
         run({3'b100, 3'h4 >> i, 10'h000}, {3'h0, v[2:0]});
         chk(rep, 1'b0);
         cv[i] = v & (i == 0 ? fcm_pkg::CTRL_MASK : i == 1 ? fcm_pkg::STAT_MASK : 32'hFFFFFFFF);
         chk(i == 0 ? arith_control_reg_q : i == 1 ? arith_status_reg_q
            : instr_address_reg_q, cv[i]);
         run({3'b101, 3'h4 >> i, 10'h000}, {i == 2 ? fcm_pkg::EA_AREG : 3'h2, 3'h3});
         chk({err, ext_result_q}, {1'b0, cv[i]});
      end
      foreach (cf[s]) begin
         ext_operand = rnd();
         run({3'b100, s < 2 ? 3'(s * 3) : 3'(s + 3), 10'h000}, 6'h00);
         chk({err, arith_control_reg_q, arith_status_reg_q, instr_address_reg_q},
            {1'b1, cv[0], cv[1], cv[2]});
      end
      run({3'b101, fcm_pkg::SEL_CTRL, 10'h000}, {fcm_pkg::EA_AREG, 3'h1});
      chk(err, 1'b1);
      $display("test control moves done");
      // constants zero and one under each precision; both are exact
      for (int p = 0; p < 3; p++) begin
         ext_operand = 32'(p) << fcm_pkg::PREC_LSB;
         run({3'b100, fcm_pkg::SEL_CTRL, 10'h000}, 6'h00);
         for (int c = 0; c < 2; c++) begin
            r = 3'(rnd());
            ex = c == 0 ? 80'h0 : {16'h3FFF, 64'h8000_0000_0000_0000};
            run({fcm_pkg::CONST_OPC, r, c ? fcm_pkg::ROM_POW_FIRST : fcm_pkg::ROM_ZERO}, 6'h00);
            chk(fp_reg_q[r], ex);
            fpm[r] = ex;
            chk(arith_status_reg_q[27:8], {c == 0 ? 4'h4 : 4'h0, cv[1][23:16], 8'h00});
         end
      end
      $display("test constant load done");
      // multiple moves over every mode, full, random and empty lists
      pending_exc = 1'b1;
      foreach (cf[c]) for (int t = 0; t < 3; t++) begin
         {dir, pre} = {cf[c][5], ~cf[c][4]};
         v = rnd();
         m = t == 0 ? 8'hFF : t == 1 ? v[7:0] : 8'h00;
         dyn_reg = {v[31:8], m};
         base_addr = {rnd() | 32'h0000_1000} & 32'h0FFF_FFFC;
         run({2'b11, dir, cf[c][4:3], 3'b000, cf[c][3] ? 8'h70 : m}, {cf[c][2:0], 3'h5});
         @(negedge clk); // host logs the last load a cycle late
         k = 0;
         for (int j = 0; j < 8; j++) begin
            r = pre ? 3'(7 - j) : 3'(j);
            if (listed(pre, m, r)) begin
               chk({xr[k], xs[k], xa[k]}, {r, dir, pre ? base_addr - 32'(12 * (k + 1))
                  : base_addr + 32'(12 * k)});
               if (dir) chk(xi[k], {fpm[r][79:64], 16'h0000, fpm[r][63:0]});
               else chk(fp_reg_q[r], mem.ld[r]);
               if (!dir) fpm[r] = mem.ld[r];
               k++;
            end
         end
         chk({err, rep, 32'(nx)}, {2'b00, 32'(k)});
         if (cf[c][2:0] != 3'h2 && cf[c][2:0] != 3'h5)
            chk(final_addr_q, pre ? base_addr - 32'(12 * k)
               : base_addr + 32'(12 * k));
      end
      run({2'b11, 1'b0, fcm_pkg::MM_STAT_PRE, 3'b000, 8'h0F}, {fcm_pkg::EA_PREDEC, 3'h1});
      chk(err, 1'b1);
      run({2'b11, 1'b1, fcm_pkg::MM_STAT_POST, 3'b000, 8'h0F}, {fcm_pkg::EA_POSTINC, 3'h1});
      chk(err, 1'b1);
      $display("test multiple moves done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
